/* File: rtl/isc_pkg.sv */
// shared constants, types and helpers of the shading correction block
package isc_pkg;
  // ========================================================
  // pixel and map geometry
  localparam int PIX_W = 12;
  localparam int NUM_W = 2 * PIX_W;
  localparam int CELL_SH = 4;
  localparam int MAP_NX = 9;
  localparam int MAP_NY = 9;
  localparam int MAP_N = MAP_NX * MAP_NY;
  localparam int SLOTS = 12;
  localparam int FIFO_W = PIX_W + 2;
  localparam int FIFO_DEPTH = 8;
  localparam int DIV_STEPS = NUM_W;
  localparam logic [3:0] FIRST_MAP_SLOT = 4'h0;
  localparam logic [3:0] LAST_MAP_SLOT = 4'hb;
  localparam logic [4:0] CELL_UNITY = 5'h10;
  // ========================================================
  // register map and fields
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_SLOT = 4'h4;
  localparam logic [3:0] OFS_STAT = 4'h8;
  localparam logic [3:0] OFS_NORM = 4'hc;
  localparam int CTRL_EN = 0;
  localparam int CTRL_BUILD = 1;
  localparam int CTRL_STORE = 2;
  localparam int CTRL_RECALL = 3;
  localparam int CTRL_FMT = 4;
  localparam logic [1:0] FMT_8 = 2'h0;
  localparam logic [1:0] FMT_10 = 2'h1;
  localparam logic [1:0] FMT_12 = 2'h2;
  localparam logic [1:0] FMT_RST = FMT_12;
  localparam logic [11:0] NORM_RST = 12'h000;
  // ========================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE, ST_CALC, ST_DIV, ST_OUT, ST_STORE, ST_RECALL
  } isc_state_t;

  function automatic logic [11:0] fmt_max(logic [1:0] f);
    unique case (f)
      FMT_8: fmt_max = 12'h0ff;
      FMT_10: fmt_max = 12'h3ff;
      default: fmt_max = 12'hfff;
    endcase
  endfunction : fmt_max
endpackage : isc_pkg

/* File: rtl/isc_stream_if.sv */
// valid/ready word stream between the block's own modules
`timescale 1ns/10ps
`default_nettype none
interface isc_stream_if #(parameter int W = 14);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : isc_stream_if
`default_nettype wire

/* File: rtl/isc_fifo.sv */
// pixel fifo with parameter width and depth
`timescale 1ns/10ps
`default_nettype none
module isc_fifo #(
  parameter int W = 14,
  parameter int D = 8
) (
  input wire logic clock_i,
  input wire logic rstn_i,
  isc_stream_if.snk wr_s,
  isc_stream_if.src rd_s
);
  // ========================================================
  // state
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } isc_fifo_t;
  isc_fifo_t q_ff;
  isc_fifo_t nxt_q;
  logic [W-1:0] mem [D];
  logic push;
  logic pop;

  assign wr_s.ready = (q_ff.cnt != (AW+1)'(D));
  assign rd_s.valid = (q_ff.cnt != '0);
  assign rd_s.data = mem[q_ff.rp];
  assign push = wr_s.valid && wr_s.ready;
  assign pop = rd_s.valid && rd_s.ready;

  // ========================================================
  // pointers; depth must be a power of two so they wrap
  always_comb
  begin
    nxt_q = q_ff;
    if (push)
      nxt_q.wp = q_ff.wp + 1'b1;
    if (pop)
      nxt_q.rp = q_ff.rp + 1'b1;
    nxt_q.cnt = q_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      q_ff <= '0;
    else
      q_ff <= nxt_q;
  end

  always_ff @(posedge clock_i)
  begin
    if (push)
      mem[q_ff.wp] <= wr_s.data;
  end
endmodule : isc_fifo
`default_nettype wire

/* File: rtl/isc_div.sv */
// sequential restoring divider for the correction quotient
`timescale 1ns/10ps
`default_nettype none
module isc_div
  import isc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic [NUM_W-1:0] num_i,
  input wire logic [PIX_W-1:0] den_i,
  output logic done_o,
  output logic [NUM_W-1:0] quot_o
);
  // ========================================================
  // state
  typedef struct packed {
    logic busy;
    logic done;
    logic [4:0] cnt;
    logic [PIX_W:0] rem;
    logic [NUM_W-1:0] q;
    logic [PIX_W-1:0] den;
    logic [NUM_W-1:0] num;
  } isc_div_t;
  isc_div_t q_ff;
  isc_div_t nxt_q;
  logic [PIX_W:0] trial;

  assign done_o = q_ff.done;
  assign quot_o = q_ff.q;

  // ========================================================
  // one quotient bit per clock, msb first
  always_comb
  begin
    nxt_q = q_ff;
    trial = {q_ff.rem[PIX_W-1:0], q_ff.q[NUM_W-1]};
    nxt_q.done = 1'b0;
    if (start_i && !q_ff.busy)
    begin
      nxt_q.busy = 1'b1;
      nxt_q.cnt = '0;
      nxt_q.rem = '0;
      nxt_q.q = num_i;
      nxt_q.num = num_i;
      nxt_q.den = den_i;
    end
    else if (q_ff.busy)
    begin
      if (trial >= {1'b0, q_ff.den})
        nxt_q.rem = trial - {1'b0, q_ff.den};
      else
        nxt_q.rem = trial;
      nxt_q.q = {q_ff.q[NUM_W-2:0], trial >= {1'b0, q_ff.den}};
      nxt_q.cnt = q_ff.cnt + 5'h01;
      if (q_ff.cnt == 5'(DIV_STEPS - 1))
      begin
        nxt_q.busy = 1'b0;
        nxt_q.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      q_ff <= '0;
    else
      q_ff <= nxt_q;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  quot_exact_a: assert property (done_o && q_ff.den != '0 |->
    36'(quot_o) * 36'(q_ff.den) <= 36'(q_ff.num) &&
    36'(q_ff.num) < (36'(quot_o) + 36'h1) * 36'(q_ff.den))
    else $error("quotient does not divide numerator");
endmodule : isc_div
`default_nettype wire

/* File: rtl/isc_top.sv */
// shading correction: map build, slot store/recall, bilinear divide
// How it works
// - a corrected pixel is the raw level times the map's peak level (norm), divided by the map's reference level.
// - correction is applied only while the enable bit is set, else pixels pass raw.
// - a build command arms capture of a reduced map from the next whole frame.
// - a slot selector limited to twelve slots targets both store and recall.
// - a store command copies the active map into the selected slot.
// - a recall command copies the selected slot over the active map.
// - the reduced map is expanded to pixel resolution by bilinear interpolation.
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/10ps
`default_nettype none
module isc_top
  import isc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pix_valid_i,
  output logic pix_ready_o,
  input wire logic pix_sof_i,
  input wire logic pix_eol_i,
  input wire logic [PIX_W-1:0] raw_level_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic out_sof_o,
  output logic out_eol_o,
  output logic [PIX_W-1:0] corrected_level_o
);
  // ========================================================
  // state
  typedef struct packed {
    isc_state_t st;
    logic en;
    logic [1:0] fmt;
    logic [3:0] slot;
    logic [3:0] cslot;
    logic armed;
    logic building;
    logic map_valid;
    logic store_req;
    logic recall_req;
    logic [PIX_W-1:0] norm;
    logic [11:0] x;
    logic [11:0] y;
    logic [PIX_W-1:0] raw;
    logic [PIX_W-1:0] refl;
    logic [6:0] idx;
    logic sof;
    logic eol;
    logic [PIX_W-1:0] out_data;
    logic ack;
    logic [31:0] rdat;
  } isc_core_t;
  isc_core_t q_ff;
  isc_core_t nxt_q;

  logic [PIX_W-1:0] map_mem [MAP_N];
  logic [PIX_W-1:0] nvm_mem [SLOTS * MAP_N];
  logic [PIX_W-1:0] nvm_norm [SLOTS];
  logic map_we;
  logic [6:0] map_wa;
  logic [PIX_W-1:0] map_wd;
  logic nvm_we;
  logic [9:0] nvm_a;
  logic [PIX_W-1:0] nvm_wd;
  logic pop;
  logic bld;
  logic use_corr;
  logic [11:0] px;
  logic [11:0] py;
  logic [8:0] cxf;
  logic [8:0] cyf;
  logic [6:0] i00;
  logic [19:0] ref_full;
  logic div_start;
  logic div_done;
  logic [NUM_W-1:0] div_q;

  isc_stream_if #(.W(FIFO_W)) in_s ();
  isc_stream_if #(.W(FIFO_W)) buf_s ();

  assign in_s.valid = pix_valid_i;
  assign in_s.data = {pix_sof_i, pix_eol_i, raw_level_i};
  assign pix_ready_o = in_s.ready;
  assign buf_s.ready = pop;

  // back-pressure: the fifo drains only while the datapath is idle
  isc_fifo #(.W(FIFO_W), .D(FIFO_DEPTH)) u_fifo (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .wr_s(in_s),
    .rd_s(buf_s)
  );

  isc_div u_div (
    .clock_i(clock_i),
    .rstn_i(rstn_i),
    .start_i(div_start),
    .num_i(NUM_W'(q_ff.raw) * NUM_W'(q_ff.norm)),
    .den_i(q_ff.refl),
    .done_o(div_done),
    .quot_o(div_q)
  );

  // ========================================================
  // helpers
  function automatic logic [19:0] lerp(logic [15:0] a, logic [15:0] b, logic [4:0] f);
    lerp = 20'(a) * 20'(CELL_UNITY - f) + 20'(b) * 20'(f);
  endfunction : lerp

  // {cell, fraction}; pixels past the last node hold the fraction at unity and take the last node's level
  function automatic logic [8:0] cell_of(logic [11:0] c);
    logic [11:0] base;
    base = 12'(MAP_NX - 2) << CELL_SH;
    if (c[11:CELL_SH] < 8'(MAP_NX - 1))
      cell_of = {c[7:CELL_SH], 1'b0, c[CELL_SH-1:0]};
    else if (c - base >= 12'(CELL_UNITY))
      cell_of = {4'(MAP_NX - 2), CELL_UNITY};
    else
      cell_of = {4'(MAP_NX - 2), 5'(c - base)};
  endfunction : cell_of

  function automatic logic [PIX_W-1:0] sat(logic [NUM_W-1:0] v, logic [1:0] f);
    sat = (v > NUM_W'(fmt_max(f))) ? fmt_max(f) : v[PIX_W-1:0];
  endfunction : sat

  // ========================================================
  // bilinear reference at the popped pixel
  assign px = buf_s.data[PIX_W+1] ? 12'h000 : q_ff.x;
  assign py = buf_s.data[PIX_W+1] ? 12'h000 : q_ff.y;
  assign cxf = cell_of(px);
  assign cyf = cell_of(py);
  assign i00 = 7'(cyf[8:5] * MAP_NX + cxf[8:5]);
  assign ref_full = lerp(16'(lerp(16'(map_mem[i00]), 16'(map_mem[i00 + 7'h01]), cxf[4:0])),
    16'(lerp(16'(map_mem[i00 + 7'(MAP_NX)]), 16'(map_mem[i00 + 7'(MAP_NX + 1)]),
    cxf[4:0])), cyf[4:0]);
  assign nvm_a = 10'(q_ff.cslot * MAP_N + q_ff.idx);
  assign nvm_wd = map_mem[q_ff.idx];

  // ========================================================
  // datapath, copy engine and register bus
  always_comb
  begin
    nxt_q = q_ff;
    pop = 1'b0;
    bld = q_ff.building;
    use_corr = 1'b0;
    map_we = 1'b0;
    map_wa = q_ff.idx;
    map_wd = nvm_mem[nvm_a];
    nvm_we = 1'b0;
    div_start = 1'b0;
    unique case (q_ff.st)
      ST_IDLE:
      begin
        if (q_ff.store_req && !q_ff.building)
        begin
          nxt_q.st = ST_STORE;
          nxt_q.store_req = 1'b0;
          nxt_q.idx = '0;
          nxt_q.cslot = q_ff.slot;
        end
        else if (q_ff.recall_req && !q_ff.building)
        begin
          nxt_q.st = ST_RECALL;
          nxt_q.recall_req = 1'b0;
          nxt_q.idx = '0;
          nxt_q.cslot = q_ff.slot;
        end
        else if (buf_s.valid)
        begin
          pop = 1'b1;
          nxt_q.raw = buf_s.data[PIX_W-1:0];
          nxt_q.sof = buf_s.data[PIX_W+1];
          nxt_q.eol = buf_s.data[PIX_W];
          nxt_q.x = buf_s.data[PIX_W] ? 12'h000 : px + 12'h001;
          nxt_q.y = buf_s.data[PIX_W] ? py + 12'h001 : py;
          if (buf_s.data[PIX_W+1] && q_ff.building)
          begin
            bld = 1'b0;
            nxt_q.map_valid = 1'b1;
          end
          else if (buf_s.data[PIX_W+1] && q_ff.armed)
          begin
            bld = 1'b1;
            nxt_q.armed = 1'b0;
            nxt_q.map_valid = 1'b0;
            nxt_q.norm = NORM_RST;
          end
          nxt_q.building = bld;
          // subsample one pixel per map node into volatile storage
          if (bld && px[CELL_SH-1:0] == '0 && py[CELL_SH-1:0] == '0 &&
              px[11:CELL_SH] < 8'(MAP_NX) && py[11:CELL_SH] < 8'(MAP_NY))
          begin
            map_we = 1'b1;
            map_wa = 7'(py[11:CELL_SH] * MAP_NX + px[11:CELL_SH]);
            map_wd = buf_s.data[PIX_W-1:0];
            if (buf_s.data[PIX_W-1:0] > nxt_q.norm)
              nxt_q.norm = buf_s.data[PIX_W-1:0];
          end
          use_corr = q_ff.en && nxt_q.map_valid && !bld;
          nxt_q.refl = ref_full[19:8];
          nxt_q.out_data = buf_s.data[PIX_W-1:0];
          nxt_q.st = use_corr ? ST_CALC : ST_OUT;
        end
      end
      ST_CALC:
      begin
        if (q_ff.refl == '0)
          nxt_q.st = ST_OUT;
        else
        begin
          div_start = 1'b1;
          nxt_q.st = ST_DIV;
        end
      end
      ST_DIV:
      begin
        if (div_done)
        begin
          nxt_q.out_data = sat(div_q, q_ff.fmt);
          nxt_q.st = ST_OUT;
        end
      end
      ST_OUT:
      begin
        if (out_ready_i)
          nxt_q.st = ST_IDLE;
      end
      ST_STORE:
      begin
        nvm_we = 1'b1;
        nxt_q.idx = q_ff.idx + 7'h01;
        if (q_ff.idx == 7'(MAP_N - 1))
          nxt_q.st = ST_IDLE;
      end
      ST_RECALL:
      begin
        map_we = 1'b1;
        nxt_q.idx = q_ff.idx + 7'h01;
        if (q_ff.idx == 7'(MAP_N - 1))
        begin
          nxt_q.norm = nvm_norm[q_ff.cslot];
          nxt_q.map_valid = 1'b1;
          nxt_q.st = ST_IDLE;
        end
      end
      default:
        nxt_q.st = ST_IDLE;
    endcase
    // bus after the engine so a new command wins over its clear
    nxt_q.ack = wb_cyc_i && wb_stb_i && !q_ff.ack;
    nxt_q.rdat = '0;
    if (nxt_q.ack)
    begin
      unique case (wb_adr_i)
        OFS_CTRL: nxt_q.rdat = {26'h0, q_ff.fmt, 3'h0, q_ff.en};
        OFS_SLOT: nxt_q.rdat = {28'h0, q_ff.slot};
        OFS_STAT: nxt_q.rdat = {24'h0, q_ff.st, q_ff.recall_req, q_ff.store_req,
          q_ff.building, q_ff.armed, q_ff.map_valid};
        OFS_NORM: nxt_q.rdat = {20'h0, q_ff.norm};
        default: nxt_q.rdat = '0;
      endcase
      if (wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_CTRL)
      begin
        nxt_q.en = wb_dat_i[CTRL_EN];
        nxt_q.fmt = wb_dat_i[CTRL_FMT+1:CTRL_FMT];
        if (wb_dat_i[CTRL_BUILD])
          nxt_q.armed = 1'b1;
        if (wb_dat_i[CTRL_STORE])
          nxt_q.store_req = 1'b1;
        if (wb_dat_i[CTRL_RECALL])
          nxt_q.recall_req = 1'b1;
      end
      if (wb_we_i && wb_sel_i[0] && wb_adr_i == OFS_SLOT)
        nxt_q.slot = (wb_dat_i[3:0] > LAST_MAP_SLOT) ? LAST_MAP_SLOT : wb_dat_i[3:0];
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      q_ff <= '0;
      q_ff.st <= ST_IDLE;
      q_ff.fmt <= FMT_RST;
      q_ff.slot <= FIRST_MAP_SLOT;
      q_ff.norm <= NORM_RST;
    end
    else
      q_ff <= nxt_q;
  end

  // map contents carry no reset; map_valid guards them after reset
  always_ff @(posedge clock_i)
  begin
    if (map_we)
      map_mem[map_wa] <= map_wd;
    if (nvm_we)
      nvm_mem[nvm_a] <= nvm_wd;
    if (nvm_we && q_ff.idx == 7'(MAP_N - 1))
      nvm_norm[q_ff.cslot] <= q_ff.norm;
  end

  assign wb_ack_o = q_ff.ack;
  assign wb_dat_o = q_ff.rdat;
  assign out_valid_o = (q_ff.st == ST_OUT);
  assign out_sof_o = q_ff.sof;
  assign out_eol_o = q_ff.eol;
  assign corrected_level_o = q_ff.out_data;

  // ========================================================
  // checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  bypass_pass_a: assert property (pop && !use_corr |=>
    out_valid_o && corrected_level_o == $past(buf_s.data[PIX_W-1:0]))
    else $error("uncorrected pixel not passed raw");
  sat_limit_a: assert property (out_valid_o && q_ff.en && q_ff.map_valid |->
    corrected_level_o <= fmt_max(q_ff.fmt) || corrected_level_o == q_ff.raw)
    else $error("corrected level above format maximum");
  zero_unity_a: assert property (q_ff.st == ST_CALC && q_ff.refl == '0 |=>
    out_valid_o && corrected_level_o == $past(q_ff.raw))
    else $error("zero reference not treated as unity");
  build_start_a: assert property (pop && buf_s.data[PIX_W+1] && q_ff.armed &&
    !q_ff.building |=> q_ff.building && !q_ff.map_valid && !q_ff.armed)
    else $error("build did not start on next frame");
  slot_range_a: assert property (q_ff.slot <= LAST_MAP_SLOT)
    else $error("slot selector out of range");
  store_copy_a: assert property (q_ff.st == ST_STORE |=>
    nvm_mem[$past(nvm_a)] == $past(nvm_wd))
    else $error("store did not copy map word");
  recall_end_a: assert property (q_ff.st == ST_RECALL && q_ff.idx == 7'(MAP_N - 1) |=>
    q_ff.map_valid && q_ff.st == ST_IDLE && q_ff.norm == $past(nvm_norm[q_ff.cslot]))
    else $error("recall did not complete");
  valid_cause_a: assert property ($rose(q_ff.map_valid) |->
    $past(q_ff.st) == ST_RECALL || $past(q_ff.building))
    else $error("map valid without build or recall");
  node_exact_a: assert property (pop && q_ff.map_valid &&
    cxf[4:0] == '0 && cyf[4:0] == '0 |-> ref_full[19:8] == map_mem[i00])
    else $error("interpolation off at map node");
  div_path_a: assert property (q_ff.st == ST_DIV && div_done |=>
    out_valid_o ##1 (out_valid_o || q_ff.st == ST_IDLE))
    else $error("quotient not presented");
endmodule : isc_top
`default_nettype wire

/* File: verification/isc_pix_model.sv */
// pixel source and sink standing at the stream ports of the block
`timescale 1ns/10ps
`default_nettype none
module isc_pix_model
  import isc_pkg::*;
(
  input wire logic clock_i,
  input wire logic pix_ready_i,
  output logic pix_valid_o,
  output logic pix_sof_o,
  output logic pix_eol_o,
  output logic [PIX_W-1:0] raw_level_o,
  input wire logic out_valid_i,
  output logic out_ready_o,
  input wire logic [PIX_W-1:0] corrected_level_i
);
  logic slow;
  logic full_seen;
  logic [PIX_W-1:0] got[$];

  initial
  begin
    slow = 1'b0;
    full_seen = 1'b0;
    pix_valid_o = 1'b0;
    pix_sof_o = 1'b0;
    pix_eol_o = 1'b0;
    raw_level_o = 12'h000;
    out_ready_o = 1'b1;
  end

  // ========================================================
  // source
  // mode 0: map frame with a bright band and a dark right edge
  function automatic logic [PIX_W-1:0] level(input int mode, input int x);
    if (mode == 0)
      return (x < 64) ? 12'h080 : (x < 112) ? 12'h100 : 12'h000;
    case (x)
      0: return 12'h123;
      8: return 12'h0ff;
      56: return 12'h0c0;
      64: return 12'h345;
      104: return 12'h800;
      128: return 12'h777;
      default: return 12'h010;
    endcase
  endfunction : level

  // full window from the origin, exactly one frame per call
  task automatic send(input int w, input int h, input int mode);
    @(posedge clock_i);
    for (int y = 0; y < h; y++)
      for (int x = 0; x < w; x++)
      begin
        pix_valid_o <= 1'b1;
        pix_sof_o <= (x == 0 && y == 0);
        pix_eol_o <= (x == w - 1);
        raw_level_o <= level(mode, x);
        @(posedge clock_i);
        while (pix_ready_i !== 1'b1)
        begin
          full_seen = 1'b1;
          @(posedge clock_i);
        end
      end
    pix_valid_o <= 1'b0;
    pix_sof_o <= 1'b0;
    pix_eol_o <= 1'b0;
    // released data must not look like the last pixel
    raw_level_o <= ~raw_level_o;
  endtask : send

  // ========================================================
  // sink, stalls every other cycle when slow
  always @(posedge clock_i)
  begin
    if (out_valid_i === 1'b1 && out_ready_o === 1'b1)
      got.push_back(corrected_level_i);
    out_ready_o <= slow ? ~out_ready_o : 1'b1;
  end
endmodule : isc_pix_model
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench of the shading correction block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import isc_pkg::*;
  logic clock_i = 1'b0;
  logic rstn_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic pix_valid_i, pix_ready_o, pix_sof_i, pix_eol_i;
  logic [PIX_W-1:0] raw_level_i, corrected_level_o;
  logic out_valid_o, out_ready_i;
  logic out_sof_o, out_eol_o;
  int n_sof = 0;
  int n_eol = 0;
  int errors = 0;
  int n_tests = 0;

  always #50 clock_i = ~clock_i;

  isc_top i_isc_top (.clock_i(clock_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o), .pix_sof_i(pix_sof_i),
    .pix_eol_i(pix_eol_i), .raw_level_i(raw_level_i), .out_valid_o(out_valid_o),
    .out_ready_i(out_ready_i), .out_sof_o(out_sof_o), .out_eol_o(out_eol_o),
    .corrected_level_o(corrected_level_o));

  isc_pix_model i_isc_pix_model (.clock_i(clock_i), .pix_ready_i(pix_ready_o),
    .pix_valid_o(pix_valid_i), .pix_sof_o(pix_sof_i), .pix_eol_o(pix_eol_i),
    .raw_level_o(raw_level_i), .out_valid_i(out_valid_o), .out_ready_o(out_ready_i),
    .corrected_level_i(corrected_level_o));

  // frame flags counted on every accepted output pixel
  always @(posedge clock_i)
  begin
    if (out_valid_o === 1'b1 && out_ready_i === 1'b1)
    begin
      n_sof <= n_sof + (out_sof_o === 1'b1);
      n_eol <= n_eol + (out_eol_o === 1'b1);
    end
  end

  // ========================================================
  // tasks
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd,
    output logic [31:0] rd);
    @(posedge clock_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= 4'hf;
    @(posedge clock_i);
    while (wb_ack_o !== 1'b1)
      @(posedge clock_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb

  task automatic wr(input logic [3:0] adr, input logic [31:0] wd);
    logic [31:0] d;
    wb(1'b1, adr, wd, d);
  endtask : wr

  task automatic rdc(input logic [3:0] adr, input logic [31:0] exp);
    logic [31:0] d;
    wb(1'b0, adr, 32'h0, d);
    check(d, exp);
  endtask : rdc

  // poll until idle with nothing pending
  task automatic settle();
    logic [31:0] d;
    int n;
    n = 0;
    d = 32'hff;
    while (d[7:1] !== 7'h00 && n < 200)
    begin
      wb(1'b0, OFS_STAT, 32'h0, d);
      n++;
    end
    check({24'h0, d[7:1], 1'b0}, 32'h0);
  endtask : settle

  task automatic run(input int w, input int h, input int mode, input logic s);
    i_isc_pix_model.got.delete();
    i_isc_pix_model.slow = s;
    i_isc_pix_model.send(w, h, mode);
    while (i_isc_pix_model.got.size() < w * h)
      @(posedge clock_i);
  endtask : run

  function automatic logic [31:0] px(input int i);
    return {20'h0, i_isc_pix_model.got[i]};
  endfunction : px

  // ========================================================
  // watchdog, sized above the long map frame
  initial
  begin
    repeat (90000) @(posedge clock_i);
    errors++;
    close_out();
  end

  // ========================================================
  // tests
  initial
  begin
    repeat (10) @(posedge clock_i);
    rstn_i <= 1'b1;
    rdc(OFS_CTRL, 32'h20);
    rdc(OFS_STAT, 32'h0);
    rdc(OFS_NORM, 32'h0);
    rdc(4'h2, 32'h0);
    wr(OFS_SLOT, 32'hf);
    rdc(OFS_SLOT, 32'hb);
    wr(OFS_SLOT, 32'h3);
    rdc(OFS_SLOT, 32'h3);
    wr(OFS_CTRL, 32'h22); // defect fix sits upstream of this block
    rdc(OFS_STAT, 32'h2);
    run(129, 129, 0, 1'b0);
    check(px(1), 32'h080);
    check(px(16640), 32'h000);
    run(1, 1, 1, 1'b0);
    rdc(OFS_STAT, 32'h1);
    rdc(OFS_NORM, 32'h100);
    wr(OFS_CTRL, 32'h21);
    run(129, 1, 1, 1'b1);
    check(px(0), 32'h246);
    check(px(8), 32'h1fe);
    check(px(56), 32'h100);
    check(px(64), 32'h345);
    check(px(128), 32'h777);
    check(px(104), 32'hfff);
    check({31'h0, i_isc_pix_model.full_seen}, 32'h1);
    wr(OFS_CTRL, 32'h25);
    settle();
    rdc(OFS_CTRL, 32'h21);
    wr(OFS_CTRL, 32'h01);
    run(129, 1, 1, 1'b0);
    check(px(0), 32'h0ff);
    check(px(8), 32'h0ff);
    check(px(1), 32'h020);
    wr(OFS_CTRL, 32'h20);
    run(129, 1, 1, 1'b0);
    check(px(0), 32'h123);
    check(px(8), 32'h0ff);
    // second reset: map gone, slots kept
    rstn_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    rstn_i <= 1'b1;
    rdc(OFS_STAT, 32'h0);
    rdc(OFS_SLOT, 32'h0);
    wr(OFS_CTRL, 32'h21);
    run(129, 1, 1, 1'b0);
    check(px(0), 32'h123);
    wr(OFS_SLOT, 32'h3);
    wr(OFS_CTRL, 32'h19);
    settle();
    rdc(OFS_STAT, 32'h1);
    run(129, 1, 1, 1'b0);
    check(px(0), 32'h246);
    check(px(56), 32'h100);
    check(px(104), 32'h3ff);
    // let the last accepted pixel reach the flag counters
    @(posedge clock_i);
    check(n_sof, 32'h7);
    check(n_eol, 32'h87);
    close_out();
  end
endmodule : testbench
`default_nettype wire
